// ### core/sep_pkg.sv
/*
  Shared constants and types for the serial memory front end and its master.
  Assumes one 10 MHz system clock on both ends; the link is sampled, not clocked.
*/
package sep_pkg;
  // System clock and link timing
  localparam int SYS_CLK_NS    = 100;  // System clock period, ns
  localparam int LINK_HALF_NS  = 800;  // Master's serial clock half period, ns
  localparam int LINK_HALF_CYC = (LINK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

  // Framing
  localparam int BYTE_BITS  = 8;  // Bits per field unit
  localparam int ADDR_BYTES = 2;  // Address bytes after an addressed op
  localparam int FIFO_DEPTH = 4;  // Write data buffer depth

  // Instruction codes
  localparam logic [7:0] SET_WRITE_LATCH_CMD   = 8'h06;
  localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
  localparam logic [7:0] STATUS_FETCH_CMD      = 8'h05;
  localparam logic [7:0] STATUS_STORE_CMD      = 8'h01;
  localparam logic [7:0] ARRAY_READ_CMD        = 8'h03;
  localparam logic [7:0] ARRAY_WRITE_CMD       = 8'h02;
  localparam logic [7:0] ID_PAGE_FETCH_CMD     = 8'h83;
  localparam logic [7:0] ID_PAGE_STORE_CMD     = 8'h82;
  // Lock ops share codes with id page ops; the address tells them apart
  localparam logic [7:0] LOCK_STATE_FETCH_CMD  = ID_PAGE_FETCH_CMD;
  localparam logic [7:0] ID_PAGE_LOCK_CMD      = ID_PAGE_STORE_CMD;

  // Status byte layout
  localparam int STAT_BUSY_BIT = 0;  // busy_flag position
  localparam int STAT_WEL_BIT  = 1;  // write_enable_latch position

  // Link sample vector layout and reset values
  localparam int         LK_SCLK  = 0;
  localparam int         LK_CSN   = 1;
  localparam int         LK_MOSI  = 2;
  localparam int         LK_HOLDN = 3;
  localparam int         LK_W     = 4;
  localparam logic [3:0] LK_RST   = 4'h0;  // Low select at reset shows no fall
  localparam logic       WEL_RST  = 1'b0;  // Latch clear after power-up
  localparam logic [15:0] ADDR_RST = 16'h0000;

  // Device end state, one-hot
  typedef enum logic [5:0] {
    DS_CMD    = 6'b000001,
    DS_ADDR   = 6'b000010,
    DS_WDATA  = 6'b000100,
    DS_RDATA  = 6'b001000,
    DS_LATCH  = 6'b010000,
    DS_IGNORE = 6'b100000
  } sep_dev_st_t;

  // Master end state, one-hot
  typedef enum logic [3:0] {
    HS_IDLE = 4'b0001,
    HS_LOW  = 4'b0010,
    HS_HIGH = 4'b0100,
    HS_GAP  = 4'b1000
  } sep_host_st_t;
endpackage

// ### core/sep_link_if.sv
/*
  Serial link between the master end and the memory front end.
  Assumes the output line idles high through a pull-up when not driven.
*/
`timescale 1ns/1ps
interface sep_link_if;
  logic sclk;       // Serial clock from master
  logic cs_n;       // Select, active low
  logic mosi;       // Data into the memory
  logic hold_n;     // Pause, active low
  logic miso;       // Data out of the memory
  logic miso_oe;    // Memory drives its output
  logic miso_line;  // Resolved line level

  // Pull-up stands in for the floating line
  assign miso_line = miso_oe ? miso : 1'b1;

  modport dev  (input sclk, cs_n, mosi, hold_n, output miso, miso_oe);
  modport host (output sclk, cs_n, mosi, hold_n, input miso_line);
endinterface

// ### core/sep_dev.sv
/*
  Memory side of the serial link: command framing, pause, read shifting and
  write acceptance, plus the write data buffer.
  Assumes a write engine outside that reports busy and completion, serves
  read bytes by address, and drains the buffer.
*/
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module sep_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             i_sys_clk,  // System clock
  input  wire logic             i_nrst,     // Async reset, active low
  input  wire logic             i_flush,    // Drop every stored word
  input  wire logic [WIDTH-1:0] i_data,     // Fill side word
  input  wire logic             i_valid,    // Fill side valid
  output logic                  o_ready,    // Room for a word
  output logic      [WIDTH-1:0] o_data,     // Drain side word
  output logic                  o_valid,    // Word available
  input  wire logic             i_ready     // Drain side accepts
);
  localparam int         AW   = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];  // Storage, no reset needed
  logic [AW-1:0]    wr_q;           // Write pointer
  logic [AW-1:0]    rd_q;           // Read pointer
  logic [AW:0]      cnt_q;          // Fill level

  wire push = i_valid & o_ready;
  wire pop  = o_valid & i_ready;

  assign o_ready = (cnt_q != FULL);
  assign o_valid = (cnt_q != '0);
  assign o_data  = mem_q[rd_q];

  // Pointer wrap for any depth
  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    nxt = (p == LAST) ? '0 : p + 1'b1;
  endfunction

  // Storage write
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_data;
    end
  end

  // Pointers and level
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (i_flush) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= nxt(wr_q);
      if (pop) rd_q <= nxt(rd_q);
      if (push && !pop) cnt_q <= cnt_q + 1'b1;
      else if (pop && !push) cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module sep_dev
  import sep_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic        i_sys_clk,    // System clock, 10 MHz
  input  wire logic        i_nrst,       // Async reset, active low
  sep_link_if.dev          link,         // Serial link, memory side
  input  wire logic        i_busy,       // busy_flag from write engine
  input  wire logic        i_wr_done,    // Pulse: write cycle finished
  input  wire logic [7:0]  i_rd_data,    // Byte at o_rd_addr
  output logic             o_rd_next,    // Pulse: o_rd_addr changed, or a status byte started
  output logic      [15:0] o_rd_addr,    // Address of byte wanted
  output logic             o_wr_start,   // Pulse: execute buffered write
  output logic             o_wr_drop,    // Pulse: discard buffered write
  output logic      [7:0]  o_wr_cmd,     // Op of the write
  output logic      [15:0] o_wr_addr,    // Start address of the write
  output logic      [7:0]  o_wdat,       // Buffered write byte
  output logic             o_wdat_valid, // Buffered byte available
  input  wire logic        i_wdat_ready, // Engine takes a byte
  output logic             o_wel,        // write_enable_latch
  output logic             o_standby     // Standby power state
);
  logic [LK_W-1:0] s1_q, s2_q, pv_q;  // Sync stages and previous sample
  sep_dev_st_t     st_q, st_d;        // Decoder state
  logic            sel_q;             // Selected after a seen fall
  logic            pause_q;           // Paused
  logic [2:0]      bit_q;             // Bit within byte
  logic [7:0]      sr_q;              // Input shifter
  logic [7:0]      op_q;              // Latched instruction
  logic            abyte_q;           // Second address byte due
  logic            have_q;            // A data byte arrived
  logic            ovf_q;             // Buffer refused a byte
  logic [7:0]      osr_q;             // Output shifter
  logic [2:0]      obit_q;            // Output bit count
  logic            drv_q, miso_q;     // Output driven, output bit
  logic            sent_q;            // A read bit went out this frame
  logic            wel_q, stby_q;
  logic            rd_next_q, wr_start_q, wr_drop_q;
  logic [7:0]      wr_cmd_q;
  logic [15:0]     addr_q, wr_addr_q;
  logic            fifo_rdy;

  // Op decoding used by the decoder
  function automatic logic is_wr_op(input logic [7:0] op);
    is_wr_op = (op == ARRAY_WRITE_CMD) || (op == ID_PAGE_STORE_CMD) ||
               (op == STATUS_STORE_CMD);
  endfunction
  function automatic logic has_addr(input logic [7:0] op);
    has_addr = (op == ARRAY_READ_CMD) || (op == ARRAY_WRITE_CMD) ||
               (op == ID_PAGE_FETCH_CMD) || (op == ID_PAGE_STORE_CMD);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Link sampling; first stage feeds only the second
  wire [LK_W-1:0] raw = {link.hold_n, link.mosi, link.cs_n, link.sclk};
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s1_q <= LK_RST;
      s2_q <= LK_RST;
      pv_q <= LK_RST;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      pv_q <= s2_q;
    end
  end

  wire sclk    = s2_q[LK_SCLK];
  wire csn     = s2_q[LK_CSN];
  wire holdn   = s2_q[LK_HOLDN];
  wire s_rise  = sclk & ~pv_q[LK_SCLK];
  wire s_fall  = ~sclk & pv_q[LK_SCLK];
  wire cs_fall = ~csn & pv_q[LK_CSN];
  wire end_sel = sel_q & csn;                  // Deselect moment
  wire active  = sel_q & ~csn & ~pause_q;
  wire [7:0] byte_in = {sr_q[6:0], s2_q[LK_MOSI]};
  wire byte_done = s_rise & active & (bit_q == 3'd7);
  wire in_wdata  = (st_q == DS_WDATA);
  wire [7:0] stat = {6'h00, wel_q, i_busy};
  wire [7:0] src  = (op_q == STATUS_FETCH_CMD) ? stat : i_rd_data;
  // Write is judged only here, at deselect
  wire wr_ok  = in_wdata & (bit_q == 3'd0) & have_q & ~ovf_q & wel_q;
  wire wr_bad = in_wdata & ~wr_ok;
  wire lt_ok  = (st_q == DS_LATCH) & (bit_q == 3'd0);
  wire push   = byte_done & in_wdata;

  ////////////////////////////////////////////////////////////////////////////
  // Selection and pause
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sel_q   <= 1'b0;
      pause_q <= 1'b0;
    end else begin
      if (csn) sel_q <= 1'b0;
      else if (cs_fall) sel_q <= 1'b1;
      if (!sel_q || csn) pause_q <= 1'b0;
      else if (!sclk) pause_q <= ~holdn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoder next state, moved only on a finished byte
  always_comb begin
    st_d = st_q;
    if (byte_done) begin
      case (st_q)
        DS_CMD: begin
          if (i_busy && byte_in != STATUS_FETCH_CMD) st_d = DS_IGNORE;
          else if (byte_in == SET_WRITE_LATCH_CMD ||
                   byte_in == CLEAR_WRITE_LATCH_CMD) st_d = DS_LATCH;
          else if (byte_in == STATUS_FETCH_CMD) st_d = DS_RDATA;
          else if (byte_in == STATUS_STORE_CMD) st_d = DS_WDATA;
          else if (has_addr(byte_in)) st_d = DS_ADDR;
          else st_d = DS_IGNORE;
        end
        DS_ADDR: begin
          if (abyte_q) st_d = is_wr_op(op_q) ? DS_WDATA : DS_RDATA;
        end
        default: st_d = st_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input shifting, op, address and data-byte bookkeeping
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q    <= DS_CMD;
      bit_q   <= 3'd0;
      sr_q    <= 8'h00;
      op_q    <= 8'h00;
      abyte_q <= 1'b0;
      addr_q  <= ADDR_RST;
      have_q  <= 1'b0;
      ovf_q   <= 1'b0;
    end else if (!sel_q || csn) begin     // Fresh start each frame
      st_q    <= DS_CMD;
      bit_q   <= 3'd0;
      abyte_q <= 1'b0;
      have_q  <= 1'b0;
      ovf_q   <= 1'b0;
      if (st_q == DS_CMD) addr_q <= ADDR_RST;
    end else if (s_rise && !pause_q) begin  // Frozen while paused
      sr_q  <= byte_in;
      bit_q <= bit_q + 3'd1;
      st_q  <= st_d;
      if (byte_done && st_q == DS_CMD) op_q <= byte_in;
      if (byte_done && st_q == DS_ADDR) begin
        abyte_q <= ~abyte_q;
        if (abyte_q) addr_q[7:0] <= byte_in;
        else addr_q[15:8] <= byte_in;
      end
      if (push) have_q <= 1'b1;
      if (push && !fifo_rdy) ovf_q <= 1'b1;  // Lost byte spoils the write
    end else if (s_fall && active && st_q == DS_RDATA && obit_q == 3'd0 &&
                 op_q != STATUS_FETCH_CMD) begin
      addr_q <= addr_q + 16'h0001;           // Byte taken, move on
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read output: one bit per falling edge while reading
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      osr_q  <= 8'h00;
      obit_q <= 3'd0;
      drv_q  <= 1'b0;
      miso_q <= 1'b0;
      sent_q <= 1'b0;
    end else if (!sel_q || csn) begin
      obit_q <= 3'd0;
      sent_q <= 1'b0;
      drv_q  <= 1'b0;
    end else if (pause_q) begin
      drv_q  <= 1'b0;
    end else if (s_fall && st_q == DS_RDATA) begin
      drv_q  <= 1'b1;
      sent_q <= 1'b1;
      obit_q <= obit_q + 3'd1;
      if (obit_q == 3'd0) begin             // Fresh byte, MSB first
        miso_q <= src[7];
        osr_q  <= {src[6:0], 1'b0};
      end else begin
        miso_q <= osr_q[7];
        osr_q  <= {osr_q[6:0], 1'b0};
      end
    end else if (st_q == DS_RDATA && sent_q) begin  // Also at a byte edge
      drv_q  <= 1'b1;                        // Drive back after a pause
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Commit at deselect, write latch, standby and read requests
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wel_q      <= WEL_RST;
      stby_q     <= 1'b1;
      wr_start_q <= 1'b0;
      wr_drop_q  <= 1'b0;
      wr_cmd_q   <= 8'h00;
      wr_addr_q  <= ADDR_RST;
      rd_next_q  <= 1'b0;
    end else begin
      wr_start_q <= end_sel & wr_ok;
      wr_drop_q  <= end_sel & wr_bad;
      if (end_sel && wr_ok) begin
        wr_cmd_q  <= op_q;
        wr_addr_q <= addr_q;
      end
      // Set beats a completion clear landing in the same cycle
      if (end_sel && lt_ok && op_q == SET_WRITE_LATCH_CMD) wel_q <= 1'b1;
      else if (end_sel && lt_ok) wel_q <= 1'b0;
      else if (i_wr_done) wel_q <= 1'b0;
      stby_q    <= csn & ~i_busy;
      rd_next_q <= (byte_done && st_q == DS_ADDR && abyte_q) ||
                   (s_fall && active && st_q == DS_RDATA && obit_q == 3'd0);
    end
  end

  // Write data buffer; a refused byte marks the frame bad
  sep_fifo #(
    .WIDTH (8),
    .DEPTH (DEPTH)
  ) u_wbuf (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .i_flush   (wr_drop_q),
    .i_data    (byte_in),
    .i_valid   (push),
    .o_ready   (fifo_rdy),
    .o_data    (o_wdat),
    .o_valid   (o_wdat_valid),
    .i_ready   (i_wdat_ready)
  );

  assign link.miso    = miso_q;
  assign link.miso_oe = drv_q;
  assign o_rd_next    = rd_next_q;
  assign o_rd_addr    = addr_q;
  assign o_wr_start   = wr_start_q;
  assign o_wr_drop    = wr_drop_q;
  assign o_wr_cmd     = wr_cmd_q;
  assign o_wr_addr    = wr_addr_q;
  assign o_wel        = wel_q;
  assign o_standby    = stby_q;
endmodule

// ### core/sep_host.sv
/*
  Master side of the serial link: sends a byte stream in one frame and
  returns the byte heard back for each byte sent.
  Assumes the user keeps a byte valid until taken and marks the frame's last.
*/
`timescale 1ns/1ps
module sep_host
  import sep_pkg::*;
#(
  parameter int HALF_CYC = LINK_HALF_CYC
) (
  input  wire logic       i_sys_clk,   // System clock, 10 MHz
  input  wire logic       i_nrst,      // Async reset, active low
  sep_link_if.host        link,        // Serial link, master side
  input  wire logic       i_mode3,     // Clock idles high when set
  input  wire logic       i_pause,     // Ask to pause the frame
  input  wire logic       i_tx_valid,  // Byte offered
  input  wire logic [7:0] i_tx_data,   // Byte to send
  input  wire logic       i_tx_last,   // Byte ends the frame
  output logic            o_tx_ready,  // Byte will be taken
  output logic      [7:0] o_rx_data,   // Byte heard back
  output logic            o_rx_valid,  // Pulse with o_rx_data
  output logic            o_busy       // Frame in progress
);
  localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

  sep_host_st_t st_q;
  logic [7:0]   cnt_q;                   // Half period divider
  logic         m1_q, m2_q;              // Return line sync
  logic         sclk_q, csn_q, mosi_q, holdn_q;
  logic [7:0]   tx_q, rx_q, rxo_q;
  logic [2:0]   bit_q;
  logic         last_q, rdy_q, rxv_q;

  wire tick = (cnt_q == HALF_LAST) & holdn_q;   // Frozen while paused
  wire take = tick & rdy_q & i_tx_valid;

  ////////////////////////////////////////////////////////////////////////////
  // Divider and return line sync
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q <= 8'h00;
      m1_q  <= 1'b1;
      m2_q  <= 1'b1;
    end else begin
      m1_q <= link.miso_line;
      m2_q <= m1_q;
      // Paused half restarts, so the memory drives again before the next rise
      if (st_q == HS_IDLE || tick || !holdn_q) cnt_q <= 8'h00;
      else cnt_q <= cnt_q + 8'h01;
    end
  end

  // Pause changes only with the clock low
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) holdn_q <= 1'b1;
    else if (!sclk_q && cnt_q != HALF_LAST) holdn_q <= ~i_pause;  // Never as the clock rises
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencer; drives on falling, samples on rising
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q   <= HS_IDLE;
      sclk_q <= 1'b0;
      csn_q  <= 1'b1;
      mosi_q <= 1'b0;
      tx_q   <= 8'h00;
      rx_q   <= 8'h00;
      rxo_q  <= 8'h00;
      bit_q  <= 3'd0;
      last_q <= 1'b0;
      rdy_q  <= 1'b0;
      rxv_q  <= 1'b0;
    end else begin
      rxv_q <= 1'b0;
      case (st_q)
        HS_IDLE: begin
          sclk_q <= i_mode3;
          rdy_q  <= 1'b1;
          if (rdy_q && i_tx_valid) begin      // Select falls
            csn_q  <= 1'b0;
            sclk_q <= 1'b0;
            tx_q   <= i_tx_data;
            mosi_q <= i_tx_data[7];
            last_q <= i_tx_last;
            bit_q  <= 3'd0;
            rdy_q  <= 1'b0;
            st_q   <= HS_LOW;
          end
        end
        HS_LOW: begin
          if (tick) begin
            sclk_q <= 1'b1;
            rx_q   <= {rx_q[6:0], m2_q};
            st_q   <= HS_HIGH;
            rdy_q  <= (bit_q == 3'd7) & ~last_q;
          end
        end
        HS_HIGH: begin
          if (tick && bit_q == 3'd7) begin
            rxo_q <= rx_q;
            rxv_q <= ~rxv_q & ~(rdy_q & ~i_tx_valid);
          end
          if (take) begin                     // Next byte, no gap
            sclk_q <= 1'b0;
            tx_q   <= i_tx_data;
            mosi_q <= i_tx_data[7];
            last_q <= i_tx_last;
            bit_q  <= 3'd0;
            rdy_q  <= 1'b0;
            st_q   <= HS_LOW;
          end else if (tick && bit_q == 3'd7 && last_q) begin
            sclk_q <= i_mode3;                // Whole bytes only
            st_q   <= HS_GAP;
          end else if (tick && bit_q != 3'd7) begin
            sclk_q <= 1'b0;
            tx_q   <= {tx_q[6:0], 1'b0};
            mosi_q <= tx_q[6];
            bit_q  <= bit_q + 3'd1;
            st_q   <= HS_LOW;
          end
        end
        HS_GAP: begin
          if (tick && !csn_q) csn_q <= 1'b1;
          else if (tick) st_q <= HS_IDLE;
        end
        default: st_q <= HS_IDLE;
      endcase
    end
  end

  assign link.sclk   = sclk_q;
  assign link.cs_n   = csn_q;
  assign link.mosi   = mosi_q;
  assign link.hold_n = holdn_q;
  assign o_tx_ready  = rdy_q;
  assign o_rx_data   = rxo_q;
  assign o_rx_valid  = rxv_q;
  assign o_busy      = (st_q != HS_IDLE);
endmodule

// ### bench/sep_link_checker.sv
/* Link checker: timing and framing of the serial link between both ends.
   Assumes the bench wires it by name beside the link interface. */
`timescale 1ns/1ps
module sep_link_checker (
  input wire logic i_sys_clk, // System clock
  input wire logic i_nrst,    // Reset, active low
  input wire logic sclk,      // Serial clock
  input wire logic cs_n,      // Select, active low
  input wire logic mosi,      // Data into memory
  input wire logic hold_n,    // Pause, active low
  input wire logic miso,      // Memory data
  input wire logic miso_oe,   // Memory drives
  input wire logic miso_line  // Resolved line
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  logic       sclk_q;                  // Serial clock a cycle ago
  logic [3:0] fall_q;                  // Cycles since clock fell
  wire        fell_w = sclk_q & ~sclk; // Falling serial clock
  ////////////////////////////////////////////////////////////////////////////
  // Age of the last fall; saturates so idle links never wrap
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sclk_q <= 1'b0;
      fall_q <= 4'hf;
    end else begin
      sclk_q <= sclk;
      fall_q <= fell_w ? 4'h0 : fall_q + {3'h0, ~&fall_q};
    end
  end
  // Read data flowing with select low and no pause
  sequence s_read_run;
    (miso_oe && !cs_n && hold_n)[*4];
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_out_after_fall: assert property (miso_oe && $changed(miso) |-> fall_q <= 4'h6)
    else $error("read bit moved away from a falling clock");
  a_float_desel: assert property (cs_n[*5] |-> !miso_oe)
    else $error("output driven while deselected");
  a_float_pause: assert property ((!hold_n && !sclk)[*5] |-> !miso_oe && miso_line)
    else $error("output driven while paused");
  a_read_keeps: assert property (s_read_run ##1 (!cs_n && hold_n) |-> miso_oe)
    else $error("read data stopped before deselect");
  a_pause_enter: assert property ($fell(hold_n) |-> !sclk)
    else $error("pause began with clock high");
  a_pause_exit: assert property ($rose(hold_n) |-> !sclk)
    else $error("pause ended with clock high");
  a_half_min: assert property ($changed(sclk) |=> $stable(sclk)[*3])
    else $error("serial clock half period too short");
  a_mosi_settled: assert property ($rose(sclk) && !cs_n |-> $stable(mosi))
    else $error("input bit moved at rising clock");
  a_desel_gap: assert property ($rose(cs_n) |=> cs_n[*2])
    else $error("select gap too short");
endmodule

// ### bench/sep_test.sv
/* Bench: host end drives frames into the memory end; bench plays engine.
   Assumes the package constants and default link timing. */
`timescale 1ns/1ps
module sep_test;
  import sep_pkg::*;
  logic clk, nrst, mode3, pause, tv, tl, tr, rxv, busy, eb, wdone, wdrdy, wst, wdr, wdv, write_enable_latch, stby;
  logic [7:0]  td, rxd, rdd, wcmd, wdat; // Byte lanes
  logic [15:0] raddr, waddr, n_st, n_dr; // Addresses and counts
  logic [7:0]  rx[$], wq[$];             // Heard bytes, drained bytes
  int          err_total, compares;      // Verdict counters
  sep_link_if u_sep_link_if ();
  sep_host u_sep_host (.i_sys_clk(clk), .i_nrst(nrst), .link(u_sep_link_if.host),
    .i_mode3(mode3), .i_pause(pause), .i_tx_valid(tv), .i_tx_data(td), .i_tx_last(tl),
    .o_tx_ready(tr), .o_rx_data(rxd), .o_rx_valid(rxv), .o_busy(busy));
  sep_dev u_sep_dev (.i_sys_clk(clk), .i_nrst(nrst), .link(u_sep_link_if.dev), .i_busy(eb),
    .i_wr_done(wdone), .i_rd_data(rdd), .o_rd_next(), .o_rd_addr(raddr), .o_wr_start(wst),
    .o_wr_drop(wdr), .o_wr_cmd(wcmd), .o_wr_addr(waddr), .o_wdat(wdat), .o_wdat_valid(wdv),
    .i_wdat_ready(wdrdy), .o_wel(write_enable_latch), .o_standby(stby));
  sep_link_checker u_chk (.i_sys_clk(clk), .i_nrst(nrst), .sclk(u_sep_link_if.sclk),
    .cs_n(u_sep_link_if.cs_n), .mosi(u_sep_link_if.mosi), .hold_n(u_sep_link_if.hold_n),
    .miso(u_sep_link_if.miso), .miso_oe(u_sep_link_if.miso_oe),
    .miso_line(u_sep_link_if.miso_line));
  ////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    give_verdict();
  end
  // Engine stand-in: array byte is address low ^ a5
  always @(posedge clk) rdd <= #1 raddr[7:0] ^ 8'ha5;
  // Monitors sample away from the launching edge
  always @(negedge clk) begin
    if (rxv === 1'b1) rx.push_back(rxd);
    if (wdv === 1'b1 && wdrdy === 1'b1) wq.push_back(wdat);
    if (wst === 1'b1) n_st++;
    if (wdr === 1'b1) n_dr++;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (err_total == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // One frame: each byte held until taken (ready seen high, then low)
  task automatic xfer(input logic [7:0] b[$]);
    int w;
    logic p;
    rx = {};
    #1;
    foreach (b[i]) begin
      tv = 1'b1;
      td = b[i];
      tl = (i == b.size() - 1);
      w = 0;
      do begin p = tr; @(posedge clk); #1 w++; end while (!(p === 1'b1 && tr === 1'b0) && w < 500);
      if (w >= 500) err_total++;
    end
    tv = 1'b0;
    w = 0;
    do begin @(posedge clk); w++; end while (busy !== 1'b0 && w < 500);
    if (w >= 500) err_total++;
    repeat (8) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {nrst, mode3, pause, tv, tl, eb, wdone} = 7'h00;
    {td, n_st, n_dr} = 40'h0;
    wdrdy = 1'b1;
    repeat (8) @(posedge clk);
    #1 nrst = 1'b1;
    @(posedge clk);
    xfer({STATUS_FETCH_CMD, 8'h00}); chk8(rx[1], 8'h00);
    xfer({ARRAY_WRITE_CMD, 8'h12, 8'h34, 8'h5a}); chk16(n_dr, 16'h0001);
    xfer({SET_WRITE_LATCH_CMD}); chk8({7'h0, write_enable_latch}, 8'h01);
    #1 wdrdy = 1'b0;
    wq = {};
    xfer({ARRAY_WRITE_CMD, 8'h12, 8'h34, 8'h5a, 8'hc3}); chk16(n_st, 16'h0001);
    chk16(waddr, 16'h1234); chk8(wcmd, ARRAY_WRITE_CMD);
    #1 wdrdy = 1'b1;
    repeat (4) @(posedge clk);
    chk8(wq[0], 8'h5a); chk8(wq[1], 8'hc3);
    #1 wdone = 1'b1;
    @(posedge clk);
    #1 wdone = 1'b0;
    wdrdy = 1'b0;
    xfer({SET_WRITE_LATCH_CMD});
    xfer({ARRAY_WRITE_CMD, 8'h00, 8'h08, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05});
    chk16(n_dr, 16'h0002);
    #1 wdrdy = 1'b1;
    xfer({ARRAY_WRITE_CMD, 8'h00, 8'h10}); chk16(n_dr, 16'h0003);
    xfer({CLEAR_WRITE_LATCH_CMD}); chk8({7'h0, write_enable_latch}, 8'h00);
    for (int m = 0; m < 2; m++) begin
      #1 mode3 = m[0];
      repeat (4) @(posedge clk);
      fork
        xfer({ARRAY_READ_CMD, 8'h00, 8'h40, 8'h00, 8'h00});
        begin repeat (420) @(posedge clk); #1 pause = 1'b1; repeat (60) @(posedge clk); #1 pause = 1'b0; end
      join
      chk8(rx[3], 8'he5); chk8(rx[4], 8'he4);
    end
    xfer({8'hff, STATUS_FETCH_CMD, 8'h00}); chk8(rx[2], 8'hff);
    #1 eb = 1'b1;
    xfer({STATUS_FETCH_CMD, 8'h00}); chk8(rx[1], 8'h01); chk8({7'h0, stby}, 8'h00);
    xfer({ARRAY_READ_CMD, 8'h00, 8'h40, 8'h00}); chk8(rx[3], 8'hff);
    #1 eb = 1'b0;
    repeat (4) @(posedge clk);
    chk8({7'h0, stby}, 8'h01);
    give_verdict();
  end
endmodule
